/* File: pkg/cra_defines.svh */
// constants of the configuration access message interpreter
//
// Notes on behaviour
// - status access moves exactly one whole word
// - config write: 192, chan, regnum, word, 1
// - config read: 193, chan, regnum, 1
// - write reply: 3,1 on success; 4,1 failure
// - config read reply: 3, word, 1; else 4,1
// - peripheral write: 36, chan, reg, size, data, 1
// - peripheral read: 37, chan, reg, size, 1
// - peripheral read reply: 3, bytes, 1; else 4,1
`ifndef CRA_DEFINES_SVH
`define CRA_DEFINES_SVH

`define CRA_TOK_CFG_WR   8'hC0
`define CRA_TOK_CFG_RD   8'hC1
`define CRA_TOK_PER_WR   8'h24
`define CRA_TOK_PER_RD   8'h25
`define CRA_TOK_END      8'h01
`define CRA_TOK_ACK      8'h03
`define CRA_TOK_NAK      8'h04
`define CRA_PS_LOW_BYTE  8'h0C
`define CRA_CHAN_LAST    8'h02
`define CRA_REGN_LAST    8'h01
`define CRA_WORD_LAST    8'h03
`define CRA_PER_MAX_SIZE 8'h04
`define CRA_SPACE_CFG    2'h0
`define CRA_SPACE_PER    2'h1
`define CRA_SPACE_PS     2'h2
`define CRA_FIFO_DEPTH   4
`define CRA_FIFO_WIDTH   33

`endif

/* File: pkg/cra_pkg.sv */
// types of the configuration access message interpreter
package cra_pkg;

    typedef enum logic [3:0] {
        CRA_IDLE,
        CRA_CHAN,
        CRA_REGN,
        CRA_SIZE,
        CRA_DATA,
        CRA_TAIL,
        CRA_ACCESS,
        CRA_REPLY,
        CRA_SKIP
    } cra_state_t;

    typedef struct packed {
        cra_state_t  st;
        logic        wr;
        logic        periph;
        logic        ps;
        logic        fail;
        logic        has_chan;
        logic [23:0] chan;
        logic [15:0] regn;
        logic [7:0]  size;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [7:0]  cnt;
        logic [1:0]  step;
        logic        ps_done;
        logic [31:0] ps_rdata;
    } cra_regs_t;

endpackage

/* File: design/cra_fifo.sv */
// small register fifo with valid and ready on both sides
`timescale 1ns/1ps
module cra_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         s_valid,
    output logic              s_ready,
    input  wire logic [W-1:0] s_data,
    output logic              m_valid,
    input  wire logic         m_ready,
    output logic [W-1:0]      m_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } cra_fifo_regs_t;

    cra_fifo_regs_t r_r;
    cra_fifo_regs_t r_nxt;
    logic           push;
    logic           pop;

    // honest full and empty from the fill count
    assign s_ready = (r_r.cnt != (AW+1)'(D));
    assign m_valid = (r_r.cnt != '0);
    assign m_data  = r_r.mem[r_r.rp];
    assign push    = s_valid && s_ready;
    assign pop     = m_valid && m_ready;

    // pointer and count update, wrapping at depth
    always_comb
    begin
        r_nxt = r_r;
        if (push)
        begin
            r_nxt.mem[r_r.wp] = s_data;
            r_nxt.wp = (r_r.wp == AW'(D-1)) ? '0 : r_r.wp + AW'(1);
        end
        if (pop)
        begin
            r_nxt.rp = (r_r.rp == AW'(D-1)) ? '0 : r_r.rp + AW'(1);
        end
        if (push && !pop)
        begin
            r_nxt.cnt = r_r.cnt + (AW+1)'(1);
        end
        else if (pop && !push)
        begin
            r_nxt.cnt = r_r.cnt - (AW+1)'(1);
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            r_r <= '0;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    chk_fifo_never_over :
        assert property (@(posedge clk) disable iff (!rst_n)
            r_r.cnt <= (AW+1)'(D))
        else $error("fifo count above depth");
endmodule

/* File: design/cra_top.sv */
// configuration access message interpreter with reply fifo
`timescale 1ns/1ps
`include "cra_defines.svh"
module cra_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic        in_ctrl,
    input  wire logic [7:0]  in_data,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic             out_ctrl,
    output logic [7:0]       out_data,
    output logic [23:0]      out_dest,
    output logic             reg_req,
    output logic             reg_wr,
    output logic [1:0]       reg_space,
    output logic [15:0]      reg_addr,
    output logic [7:0]       reg_size,
    output logic [31:0]      reg_wdata,
    input  wire logic        reg_ack,
    input  wire logic        reg_err,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        ps_req,
    output logic             ps_ready,
    input  wire logic        ps_wr,
    input  wire logic [31:0] ps_resid,
    input  wire logic [31:0] ps_wdata,
    output logic             ps_done,
    output logic             ps_fail,
    output logic [31:0]      ps_rdata
);
    cra_pkg::cra_regs_t           r;
    cra_pkg::cra_regs_t           r_nxt;
    logic                         in_fire;
    logic                         push_v;
    logic                         push_ready;
    logic                         push_ctrl;
    logic [7:0]                   push_data;
    logic [`CRA_FIFO_WIDTH-1:0]   fifo_out;
    logic                         is_end;
    logic                         open_ok;

    // ************************************************************
    // handshakes and register port
    // ************************************************************
    assign in_ready  = (r.st != cra_pkg::CRA_ACCESS)
                     && (r.st != cra_pkg::CRA_REPLY);
    assign in_fire   = in_valid && in_ready;
    assign ps_ready  = (r.st == cra_pkg::CRA_IDLE) && !in_valid;
    assign is_end    = in_ctrl && (in_data == `CRA_TOK_END);
    assign open_ok   = in_ctrl && ((in_data == `CRA_TOK_CFG_WR)
                     || (in_data == `CRA_TOK_CFG_RD)
                     || (in_data == `CRA_TOK_PER_WR)
                     || (in_data == `CRA_TOK_PER_RD));
    assign reg_req   = (r.st == cra_pkg::CRA_ACCESS) && !r.fail;
    assign reg_wr    = r.wr;
    assign reg_space = r.ps ? `CRA_SPACE_PS
                     : (r.periph ? `CRA_SPACE_PER : `CRA_SPACE_CFG);
    assign reg_addr  = r.regn;
    assign reg_size  = r.size;
    assign reg_wdata = r.wdata;
    assign ps_done   = r.ps_done;
    assign ps_fail   = r.fail;
    assign ps_rdata  = r.ps_rdata;

    // reply token chosen by reply step
    always_comb
    begin
        push_v    = (r.st == cra_pkg::CRA_REPLY);
        push_ctrl = 1'b1;
        push_data = `CRA_TOK_END;
        if (r.step == 2'h0)
        begin
            push_data = r.fail ? `CRA_TOK_NAK : `CRA_TOK_ACK;
        end
        else if (r.step == 2'h1)
        begin
            push_ctrl = 1'b0;
            push_data = r.rdata[{r.cnt[1:0], 3'b000} +: 8];
        end
    end

    // ************************************************************
    // message parser and reply sequencer
    // ************************************************************
    always_comb
    begin
        r_nxt = r;
        r_nxt.ps_done = 1'b0;
        if (ps_req && ps_ready)
        begin
            // status access: one word, number taken above low byte
            r_nxt.st    = cra_pkg::CRA_ACCESS;
            r_nxt.ps    = 1'b1;
            r_nxt.wr    = ps_wr;
            r_nxt.regn  = ps_resid[23:8];
            r_nxt.wdata = ps_wdata;
            r_nxt.fail  = (ps_resid[7:0] != `CRA_PS_LOW_BYTE);
        end
        else if (in_fire && (r.st != cra_pkg::CRA_IDLE)
                 && (r.st != cra_pkg::CRA_SKIP)
                 && (r.st != cra_pkg::CRA_TAIL) && in_ctrl)
        begin
            // control token inside a field: framing failure
            r_nxt.fail = 1'b1;
            r_nxt.step = 2'h0;
            r_nxt.st   = !is_end ? cra_pkg::CRA_SKIP
                       : (r.has_chan ? cra_pkg::CRA_REPLY
                                     : cra_pkg::CRA_IDLE);
        end
        else if (in_fire)
        begin
            unique case (r.st)
                cra_pkg::CRA_IDLE:
                begin
                    r_nxt.ps       = 1'b0;
                    r_nxt.fail     = 1'b0;
                    r_nxt.has_chan = 1'b0;
                    r_nxt.cnt      = 8'h00;
                    r_nxt.regn     = 16'h0000;
                    r_nxt.size     = 8'h00;
                    r_nxt.wdata    = 32'h0000_0000;
                    r_nxt.wr       = (in_data == `CRA_TOK_CFG_WR)
                                   || (in_data == `CRA_TOK_PER_WR);
                    r_nxt.periph   = (in_data == `CRA_TOK_PER_WR)
                                   || (in_data == `CRA_TOK_PER_RD);
                    r_nxt.st       = open_ok ? cra_pkg::CRA_CHAN
                                   : (is_end ? cra_pkg::CRA_IDLE
                                             : cra_pkg::CRA_SKIP);
                end
                cra_pkg::CRA_CHAN:
                begin
                    // reply channel, three bytes, high first
                    r_nxt.chan = {r.chan[15:0], in_data};
                    r_nxt.cnt  = r.cnt + 8'h01;
                    if (r.cnt == `CRA_CHAN_LAST)
                    begin
                        r_nxt.has_chan = 1'b1;
                        r_nxt.cnt      = 8'h00;
                        r_nxt.st       = cra_pkg::CRA_REGN;
                    end
                end
                cra_pkg::CRA_REGN:
                begin
                    r_nxt.regn = {r.regn[7:0], in_data};
                    r_nxt.cnt  = r.cnt + 8'h01;
                    if (r.periph)
                    begin
                        r_nxt.cnt = 8'h00;
                        r_nxt.st  = cra_pkg::CRA_SIZE;
                    end
                    else if (r.cnt == `CRA_REGN_LAST)
                    begin
                        r_nxt.cnt = 8'h00;
                        r_nxt.st  = r.wr ? cra_pkg::CRA_DATA
                                         : cra_pkg::CRA_TAIL;
                    end
                end
                cra_pkg::CRA_SIZE:
                begin
                    r_nxt.size = in_data;
                    if ((in_data == 8'h00)
                        || (in_data > `CRA_PER_MAX_SIZE))
                    begin
                        r_nxt.fail = 1'b1;
                        r_nxt.st   = cra_pkg::CRA_SKIP;
                    end
                    else
                    begin
                        r_nxt.st = r.wr ? cra_pkg::CRA_DATA
                                        : cra_pkg::CRA_TAIL;
                    end
                end
                cra_pkg::CRA_DATA:
                begin
                    r_nxt.wdata = {r.wdata[23:0], in_data};
                    r_nxt.cnt   = r.cnt + 8'h01;
                    if (r.cnt == (r.periph ? r.size - 8'h01
                                           : `CRA_WORD_LAST))
                    begin
                        r_nxt.st = cra_pkg::CRA_TAIL;
                    end
                end
                cra_pkg::CRA_TAIL:
                begin
                    // only the closing token may follow the fields
                    if (is_end)
                    begin
                        r_nxt.st = cra_pkg::CRA_ACCESS;
                    end
                    else
                    begin
                        r_nxt.fail = 1'b1;
                        r_nxt.st   = cra_pkg::CRA_SKIP;
                    end
                end
                cra_pkg::CRA_SKIP:
                begin
                    r_nxt.step = 2'h0;
                    if (is_end)
                    begin
                        r_nxt.fail = 1'b1;
                        r_nxt.st   = r.has_chan ? cra_pkg::CRA_REPLY
                                                : cra_pkg::CRA_IDLE;
                    end
                end
                cra_pkg::CRA_ACCESS, cra_pkg::CRA_REPLY:
                begin
                    r_nxt.st = r.st;
                end
            endcase
        end
        else if ((r.st == cra_pkg::CRA_ACCESS) && (reg_ack || r.fail))
        begin
            // register answer: reply contents only on success; ps_rdata takes reg_rdata on failure too
            r_nxt.fail  = r.fail || reg_err;
            r_nxt.rdata = reg_rdata;
            r_nxt.cnt   = r.periph ? r.size - 8'h01 : `CRA_WORD_LAST;
            r_nxt.step  = 2'h0;
            r_nxt.st    = r.ps ? cra_pkg::CRA_IDLE : cra_pkg::CRA_REPLY;
            if (r.ps)
            begin
                r_nxt.ps_done  = 1'b1;
                r_nxt.ps_rdata = reg_rdata;
            end
        end
        else if (push_v && push_ready)
        begin
            if (r.step == 2'h0)
            begin
                r_nxt.step = (!r.fail && !r.wr) ? 2'h1 : 2'h2;
            end
            else if (r.step == 2'h1)
            begin
                r_nxt.cnt = r.cnt - 8'h01;
                if (r.cnt == 8'h00)
                begin
                    r_nxt.step = 2'h2;
                end
            end
            else
            begin
                r_nxt.st = cra_pkg::CRA_IDLE;
            end
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= r_nxt;
        end
    end

    // ************************************************************
    // reply fifo: token, control flag and destination channel
    // ************************************************************
    cra_fifo #(
        .W (`CRA_FIFO_WIDTH),
        .D (`CRA_FIFO_DEPTH)
    ) u_reply_fifo (
        .clk     (clk),
        .rst_n   (rst_n),
        .s_valid (push_v),
        .s_ready (push_ready),
        .s_data  ({r.chan, push_ctrl, push_data}),
        .m_valid (out_valid),
        .m_ready (out_ready),
        .m_data  (fifo_out)
    );
    assign out_dest = fifo_out[32:9];
    assign out_ctrl = fifo_out[8];
    assign out_data = fifo_out[7:0];

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_ps_one_word : assert property (
        (ps_req && ps_ready) |=> reg_space == `CRA_SPACE_PS
            && reg_addr == $past(ps_resid[23:8])
            && reg_wdata == $past(ps_wdata))
        else $error("status access did not carry its word");
    chk_cfg_wr_close : assert property (
        (r.st == cra_pkg::CRA_TAIL && in_fire && is_end && !r.fail)
            |=> r.st == cra_pkg::CRA_ACCESS ##1 reg_req || r.fail
            || r.st != cra_pkg::CRA_ACCESS)
        else $error("closed write not served");
    chk_cfg_rd_frame : assert property (
        (r.st == cra_pkg::CRA_REGN && in_fire && !in_ctrl && !r.periph
            && !r.wr && r.cnt == 8'h01) |=> r.st == cra_pkg::CRA_TAIL)
        else $error("config read did not await close");
    chk_reply_head : assert property (
        (push_v && r.step == 2'h0) |-> push_ctrl
            && push_data == (r.fail ? `CRA_TOK_NAK : `CRA_TOK_ACK))
        else $error("wrong reply head token");
    chk_read_data : assert property (
        (push_v && !push_ctrl) |-> !r.fail && !r.wr)
        else $error("data sent in a write or failed reply");
    chk_per_wr_size : assert property (
        (r.st == cra_pkg::CRA_SIZE && in_fire && !in_ctrl && r.wr
            && in_data == 8'h01) |=> r.st == cra_pkg::CRA_DATA)
        else $error("peripheral write skipped data");
    chk_per_rd_size : assert property (
        (r.st == cra_pkg::CRA_SIZE && in_fire && !in_ctrl && !r.wr
            && in_data == 8'h02) |=> r.st == cra_pkg::CRA_TAIL)
        else $error("peripheral read did not await close");
    chk_reply_close : assert property (
        (push_v && push_ready && r.step == 2'h2) |-> push_ctrl
            && push_data == `CRA_TOK_END ##1 r.st == cra_pkg::CRA_IDLE)
        else $error("reply not closed by end token");
    chk_fail_quiet : assert property (
        (r.st == cra_pkg::CRA_SKIP) |-> !reg_req ##1 !reg_req)
        else $error("register touched on a bad message");
endmodule

/* File: dv/cra_bank_model.sv */
// register bank model that answers the register access port
`timescale 1ns/1ps
module cra_bank_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        slow,
    input  wire logic        reg_req,
    input  wire logic        reg_wr,
    input  wire logic [1:0]  reg_space,
    input  wire logic [15:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic             reg_ack,
    output logic             reg_err,
    output logic [31:0]      reg_rdata
);
    logic [31:0] mem [64];
    logic [3:0]  wait_r;
    logic        miss;
    logic [5:0]  idx;

    // only sixteen registers exist in each space
    assign miss = (reg_addr > 16'h000F);
    assign idx  = {reg_space, reg_addr[3:0]};

    // answer one or nine cycles after the request, read data garbled
    // outside an answer so a stale value is never mistaken for a result
    always_ff @(posedge clk)
    begin
        reg_ack   <= 1'b0;
        reg_err   <= 1'b0;
        reg_rdata <= ~reg_rdata;
        if (!rst_n)
        begin
            wait_r    <= 4'h0;
            reg_rdata <= 32'h5A5AA5A5;
            for (int i = 0; i < 64; i++)
                mem[i] <= 32'h0;
        end
        else if (!reg_req || reg_ack)
            wait_r <= 4'h0;
        else if (wait_r < (slow ? 4'h8 : 4'h0))
            wait_r <= wait_r + 4'h1;
        else
        begin
            reg_ack <= 1'b1;
            reg_err <= miss;
            if (!miss)
            begin
                reg_rdata <= mem[idx];
                if (reg_wr)
                    mem[idx] <= reg_wdata;
            end
        end
    end
endmodule

/* File: dv/tb.sv */
// self-checking bench for the configuration access interpreter
`timescale 1ns/1ps
module tb;
    logic        clk, rst_n, in_valid, in_ctrl, out_ready, slow;
    logic        ps_req, ps_wr, in_ready, out_valid, out_ctrl;
    logic        reg_req, reg_wr, reg_ack, reg_err, ps_ready, ps_done, ps_fail;
    logic [7:0]  in_data, out_data, reg_size;
    logic [23:0] out_dest;
    logic [1:0]  reg_space;
    logic [15:0] reg_addr;
    logic [31:0] ps_resid, ps_wdata, ps_rdata, reg_wdata, reg_rdata;
    logic [32:0] rxq [$];
    int          err_total;
    int          check_count;

    cra_top i_dut (
        .clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_ready(in_ready),
        .in_ctrl(in_ctrl), .in_data(in_data), .out_valid(out_valid),
        .out_ready(out_ready), .out_ctrl(out_ctrl), .out_data(out_data),
        .out_dest(out_dest), .reg_req(reg_req), .reg_wr(reg_wr),
        .reg_space(reg_space), .reg_addr(reg_addr), .reg_size(reg_size),
        .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_err(reg_err),
        .reg_rdata(reg_rdata), .ps_req(ps_req), .ps_ready(ps_ready),
        .ps_wr(ps_wr), .ps_resid(ps_resid), .ps_wdata(ps_wdata),
        .ps_done(ps_done), .ps_fail(ps_fail), .ps_rdata(ps_rdata)
    );

    cra_bank_model i_bank (
        .clk(clk), .rst_n(rst_n), .slow(slow), .reg_req(reg_req),
        .reg_wr(reg_wr), .reg_space(reg_space), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_err(reg_err),
        .reg_rdata(reg_rdata)
    );

    // clock of 8 ns period
    always #4 clk = ~clk;

    // collect every reply token at the edge where it is taken
    always @(posedge clk)
        if (out_valid === 1'b1 && out_ready === 1'b1)
            rxq.push_back({out_dest, out_ctrl, out_data});

    // ************************************************************
    // comparison and reporting
    // ************************************************************
    task automatic bad(input string m);
        err_total++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic chk_tok(input logic [32:0] g, input logic [32:0] e);
        check_count++;
        if (g !== e)
            bad($sformatf("reply token %h expected %h", g, e));
    endtask

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
            bad($sformatf("value %h expected %h", g, e));
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ************************************************************
    // drivers: all inputs change at the falling edge
    // ************************************************************
    // hold a token until in_ready is seen at a sampling edge
    task automatic tok(input logic c, input logic [7:0] d);
        logic taken;
        in_valid = 1'b1;
        in_ctrl  = c;
        in_data  = d;
        do
        begin
            taken = in_ready;
            @(negedge clk);
        end
        while (taken !== 1'b1);
    endtask

    // send n bytes of v, most significant first
    task automatic bytes(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            tok(1'b0, v[8*i +: 8]);
    endtask

    // opening token, channel, number field, data field, close token
    task automatic msg(input logic [7:0] op, input logic [23:0] ch,
                       input logic [15:0] rn, input logic [31:0] dt,
                       input int db, input logic hold);
        tok(1'b1, op);
        bytes({8'h00, ch}, 3);
        bytes({16'h0000, rn}, 2);
        bytes(dt, db);
        tok(1'b1, 8'h01);
        if (!hold)
            in_valid = 1'b0;
    endtask

    // wait for the next reply token, bounded
    task automatic rx(input logic [23:0] ch, input logic c,
                      input logic [7:0] d);
        int n;
        for (n = 0; n < 300 && rxq.size() == 0; n++)
            @(negedge clk);
        if (rxq.size() == 0)
            bad("reply token missing");
        else
            chk_tok(rxq.pop_front(), {ch, c, d});
    endtask

    task automatic ok_reply(input logic [23:0] ch, input logic [31:0] w,
                            input int n);
        rx(ch, 1'b1, 8'h03);
        for (int i = n - 1; i >= 0; i--)
            rx(ch, 1'b0, w[8*i +: 8]);
        rx(ch, 1'b1, 8'h01);
    endtask

    task automatic fail_reply(input logic [23:0] ch);
        rx(ch, 1'b1, 8'h04);
        rx(ch, 1'b1, 8'h01);
    endtask

    // one status access; waits for the done pulse, bounded
    task automatic ps_op(input logic w, input logic [31:0] id,
                         input logic [31:0] d, output logic f,
                         output logic [31:0] r);
        int n;
        ps_wr    = w;
        ps_resid = id;
        ps_wdata = d;
        ps_req   = 1'b1;
        @(negedge clk);
        ps_req = 1'b0;
        for (n = 0; n < 50 && ps_done !== 1'b1; n++)
            @(negedge clk);
        if (n == 50)
            bad("status access never done");
        f = ps_fail;
        r = ps_rdata;
        @(negedge clk);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    // write then read back to back, word sent most significant first
    // the requester reaches us through the tile config endpoint
    task automatic t_cfg();
        msg(8'hC0, 24'hA1B2C3, 16'h0005, 32'h12345678, 4, 1'b1);
        msg(8'hC1, 24'hA1B2C3, 16'h0005, 32'h0, 0, 1'b0);
        ok_reply(24'hA1B2C3, 32'h0, 0);
        ok_reply(24'hA1B2C3, 32'h12345678, 4);
        $display("test cfg done");
    endtask

    // missing register, bad framing, contents left alone
    // the requester reaches us through the node config endpoint
    task automatic t_bad();
        msg(8'hC0, 24'h010203, 16'h0040, 32'hDEADBEEF, 4, 1'b0);
        fail_reply(24'h010203);
        tok(1'b1, 8'hC0);
        bytes(32'h00010203, 3);
        bytes(32'h00000005, 2);
        bytes(32'hDEADBEEF, 4);
        tok(1'b0, 8'h77);
        tok(1'b1, 8'h01);
        in_valid = 1'b0;
        fail_reply(24'h010203);
        tok(1'b1, 8'hC1);
        bytes(32'h00010203, 3);
        tok(1'b0, 8'h00);
        tok(1'b1, 8'h05);
        tok(1'b1, 8'h01);
        in_valid = 1'b0;
        fail_reply(24'h010203);
        msg(8'hC1, 24'h010203, 16'h0005, 32'h0, 0, 1'b0);
        ok_reply(24'h010203, 32'h12345678, 4);
        $display("test bad done");
    endtask

    // peripheral number and size travel in the 16-bit field slot
    // the requester reaches us through node and peripheral ids
    task automatic t_per();
        msg(8'h24, 24'h0F0E0D, 16'h0302, 32'h0000AABB, 2, 1'b0);
        ok_reply(24'h0F0E0D, 32'h0, 0);
        msg(8'h25, 24'h0F0E0D, 16'h0302, 32'h0, 0, 1'b0);
        ok_reply(24'h0F0E0D, 32'h0000AABB, 2);
        msg(8'h25, 24'h0F0E0D, 16'h0300, 32'h0, 0, 1'b0);
        fail_reply(24'h0F0E0D);
        $display("test per done");
    endtask

    task automatic t_ps();
        logic        f;
        logic [31:0] r;
        ps_op(1'b1, 32'h0000050C, 32'hCAFEF00D, f, r);
        chk_word({31'h0, f}, 32'h0);
        ps_op(1'b0, 32'h0000050C, 32'h0, f, r);
        chk_word({31'h0, f}, 32'h0);
        chk_word(r, 32'hCAFEF00D);
        ps_op(1'b0, 32'h0000050D, 32'h0, f, r);
        chk_word({31'h0, f}, 32'h1);
        ps_op(1'b1, 32'h0000400C, 32'h1, f, r);
        chk_word({31'h0, f}, 32'h1);
        $display("test ps done");
    endtask

    // slow bank and stalled sink: reply fills the fifo, then drains
    task automatic t_stall();
        out_ready = 1'b0;
        slow      = 1'b1;
        msg(8'hC1, 24'h00C0DE, 16'h0005, 32'h0, 0, 1'b0);
        repeat (40) @(negedge clk);
        chk_word(rxq.size(), 32'h0);
        out_ready = 1'b1;
        slow      = 1'b0;
        ok_reply(24'h00C0DE, 32'h12345678, 4);
        $display("test stall done");
    endtask

    // main sequence
    initial
    begin
        clk         = 1'b0;
        rst_n       = 1'b0;
        in_valid    = 1'b0;
        in_ctrl     = 1'b0;
        in_data     = 8'h00;
        out_ready   = 1'b1;
        slow        = 1'b0;
        ps_req      = 1'b0;
        ps_wr       = 1'b0;
        ps_resid    = 32'h0;
        ps_wdata    = 32'h0;
        err_total   = 0;
        check_count = 0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_cfg();
        t_bad();
        t_per();
        t_ps();
        t_stall();
        summarize();
    end

    // the tests need well under 2000 cycles; allow ten times that
    initial
    begin
        #160000;
        bad("watchdog expired");
        summarize();
    end
endmodule
